/* File: verilog/dcff_cfg.svh */
// Constants of the dual-clock FIFO core: register offsets, reset values.
// Assumes inclusion by bare name from the core and its bench.
`ifndef DCFF_CFG_SVH
`define DCFF_CFG_SVH
`define DCFF_ADDR_W 8
`define DCFF_ADDR_EMPTY_OFS 8'h00
`define DCFF_ADDR_FULL_OFS 8'h04
`define DCFF_ADDR_STATUS 8'h08
`define DCFF_OFS_W 15
`define DCFF_OFS_RST 15'h007f
`define DCFF_ST_MODE 7
`define DCFF_ST_CNT_LSB 16
`endif

/* File: verilog/dcff_pkg.sv */
// Types of the dual-clock FIFO core; its bench does not use them.
// Assumes nothing of its surroundings.
package dcff_pkg;
    typedef enum logic {
        DCFF_STD = 1'b0,
        DCFF_FALL_THROUGH_MODE = 1'b1
    } dcff_mode_e;

    // Pins sampled from outside the system clock domain
    typedef struct packed {
        logic mrs_n;
        logic mode;
        logic wclk;
        logic wen_n;
        logic rclk;
        logic ren_n;
        logic [35:0] wdata;
    } dcff_pins_s;
endpackage : dcff_pkg

/* File: verilog/dcff_core.sv */
// Dual-clock 36-bit FIFO core with plain and fall-through read modes.
// Assumes write and read clocks arrive as pins much slower than clk_sys,
// and an AHB-Lite master with single word transfers for the offsets.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`include "dcff_cfg.svh"

// Timing overview of the core
// Both pin clocks are plain inputs: clk_sys samples them through three
// flops and finds their rising edges. A pin edge is seen two to three
// clk_sys cycles late. The enables and the write word travel the same
// path, so the reader and writer need only hold them for about four
// clk_sys cycles after their own clock edge.
// Trade-off: every pin clock must be much slower than clk_sys. With
// clk_sys at 25 MHz a pin clock of about 3 MHz is the practical limit.
// Above that, pin edges merge in the filter and words are lost.
// Master reset clears the pointers, the count and the output word.
// It leaves the two offsets alone, so software sets them only once.
// The read mode is caught for as long as master reset is held. A mode
// pin that moves after release has no effect until the next one.
// Count convention: the level flags compare the number of words held.
// In fall-through mode that number includes the output register. This
// gives the extra word of capacity and the one-word shift of every
// threshold, with no second set of constants.
// Limitation: all flags are built in the clk_sys domain. They are not
// aligned to either pin clock, so pin-side logic sees them change a
// few clk_sys cycles after the pin edge that caused the change.

// Function
// - Mode pin latched during master reset
// - Plain mode: every word needs a read
// - Fall-through: first word after three read edges
// - Word captured on write edge, enable low
// - Plain: empty flag high after first write
// - Plain: almost-empty high at n plus one
// - Plain: half-full low above half depth
// - Plain: almost-full low at depth minus m
// - Plain: full at depth, blocks, read frees
// - Plain: almost-empty low at n words
// - Plain: last read empties, reads then ignored
// - Plain: empty and full two-stage registered
// - Fall-through: valid flag low after first write
// - Fall-through: almost-empty high at n plus two
// - Fall-through: half-full one word later
// - Fall-through: almost-full at depth plus one minus m
// - Fall-through: ready high at depth plus one
// - Fall-through: first read when full readies
// - Fall-through: almost-empty low at n plus one
// - Fall-through: last read raises valid flag
// - Fall-through: valid three-stage, ready two-stage
module dcff_core #(
    parameter int DEPTH = 1024
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic mode_select_serial_in,
    input wire logic wr_clk,
    input wire logic wr_en_n,
    input wire logic [35:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_en_n,
    output logic [35:0] read_data_out,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic output_valid_n,
    output logic input_ready_n,
    output logic half_full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [16:0] D17 = 17'(DEPTH);
    localparam logic [16:0] HALF17 = 17'(DEPTH / 2);

    dcff_pkg::dcff_pins_s pin_in;
    dcff_pkg::dcff_pins_s s1_r;
    dcff_pkg::dcff_pins_s s2_r;
    dcff_pkg::dcff_pins_s s3_r;
    dcff_pkg::dcff_pins_s lvl_r;
    dcff_pkg::dcff_mode_e mode_r;

    logic [35:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic ov_r;
    logic ov_nxt;
    logic ne1_r;
    logic ne2_r;
    logic ef1_r;
    logic ff1_r;
    logic ir1_r;
    logic [`DCFF_OFS_W-1:0] empty_ofs_r;
    logic [`DCFF_OFS_W-1:0] full_ofs_r;
    logic dph_wr_r;
    logic [`DCFF_ADDR_W-1:0] dph_addr_r;

    logic mrs_act;
    logic fall_through_mode;
    logic wr_rise;
    logic rd_rise;
    logic full_int;
    logic empty_mem;
    logic do_wr;
    logic rd_std;
    logic take;
    logic load;
    logic pop;
    logic [16:0] tot17;
    logic [16:0] n17;
    logic [16:0] m17;
    logic [16:0] fw17;
    logic addr_ph;
    logic [31:0] status_w;

    // Pins bundled in struct field order
    // All pins share one filter, so enables and word stay aligned
    // with the clock edges that qualify them
    assign pin_in = {master_reset_n, mode_select_serial_in, wr_clk,
                     wr_en_n, rd_clk, rd_en_n, wr_data};

    // Three-stage synchroniser; a level counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= dcff_pkg::dcff_pins_s'((s2_r & s3_r)
                     | (lvl_r & (s2_r | s3_r)));
        end
    end

    // Edge found in the cycle the filtered level turns high
    // A glitch shorter than one clk_sys cycle never turns the level,
    // so it yields no false edge
    assign wr_rise = s2_r.wclk & s3_r.wclk & ~lvl_r.wclk;
    assign rd_rise = s2_r.rclk & s3_r.rclk & ~lvl_r.rclk;
    assign mrs_act = ~lvl_r.mrs_n;
    assign fall_through_mode = (mode_r == dcff_pkg::DCFF_FALL_THROUGH_MODE);

    // Mode caught from the pin for as long as master reset is held
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_r <= dcff_pkg::DCFF_STD;
        end else if (mrs_act) begin
            mode_r <= dcff_pkg::dcff_mode_e'(lvl_r.mode);
        end
    end

    // Memory full means no room; in fall-through the output word is extra
    assign full_int = (cnt_r == CW'(DEPTH));
    assign empty_mem = (cnt_r == '0);
    assign do_wr = wr_rise & ~s3_r.wen_n & ~full_int & ~mrs_act;
    // Reads on an empty memory are dropped here, not by the reader
    assign rd_std = ~fall_through_mode & rd_rise & ~s3_r.ren_n & ~empty_mem
                    & ~mrs_act;
    assign take = fall_through_mode & rd_rise & ~s3_r.ren_n & ov_r
                  & ~mrs_act;
    // Fall-through load waits for the two-stage not-empty chain
    assign load = fall_through_mode & rd_rise & ne2_r & ~empty_mem & (~ov_r | take)
                  & ~mrs_act;
    assign pop = rd_std | load;
    assign cnt_nxt = cnt_r + CW'(do_wr) - CW'(pop);
    assign ov_nxt = load | (ov_r & ~take);

    // Storage has no reset; pointers guard it
    // Flops instead of a memory macro keep reads free of latency
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem_r[wptr_r] <= s3_r.wdata;
        end
    end

    // Pointers and stored count
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
        end
    end

    // Output word moves only on a granted read or a fall-through load
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            read_data_out <= '0;
        end else if (pop) begin
            read_data_out <= mem_r[rptr_r];
        end
    end

    // Not-empty chain on read edges gives the three-edge fall-through
    // Two chain stages and the output register make the three stages
    // that the valid flag passes through
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            ne1_r <= 1'b0;
            ne2_r <= 1'b0;
        end else if (rd_rise && fall_through_mode) begin
            ne1_r <= ~empty_mem;
            ne2_r <= ne1_r;
        end
    end

    // Output register occupancy and its flag, third stage of the chain
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            ov_r <= 1'b0;
            output_valid_n <= 1'b1;
        end else begin
            ov_r <= ov_nxt;
            output_valid_n <= ~ov_nxt;
        end
    end

    // Plain mode empty flag: rises through two read-edge stages,
    // so a word written just before a read edge is not yet offered;
    // falls at once so the reader never sees a word that is gone
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            ef1_r <= 1'b0;
            empty_flag_n <= 1'b0;
        end else if (rd_rise && !fall_through_mode) begin
            ef1_r <= (cnt_nxt != '0);
            if (cnt_nxt == '0) begin
                empty_flag_n <= 1'b0;
            end else begin
                empty_flag_n <= ef1_r;
            end
        end
    end

    // Plain mode full flag: falls at once, frees through two write edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            ff1_r <= 1'b1;
            full_flag_n <= 1'b1;
        end else if (wr_rise && !fall_through_mode) begin
            ff1_r <= (cnt_nxt != CW'(DEPTH));
            if (cnt_nxt == CW'(DEPTH)) begin
                full_flag_n <= 1'b0;
            end else begin
                full_flag_n <= ff1_r;
            end
        end
    end

    // Fall-through ready flag, same two-stage scheme on write edges
    // While master reset is held it shows the mode being caught,
    // so a fall-through writer sees room at once
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ir1_r <= 1'b0;
            input_ready_n <= 1'b1;
        end else if (mrs_act) begin
            ir1_r <= 1'b0;
            input_ready_n <= ~lvl_r.mode; // unused in plain mode
        end else if (wr_rise && fall_through_mode) begin
            ir1_r <= (cnt_nxt == CW'(DEPTH));
            if (cnt_nxt == CW'(DEPTH)) begin
                input_ready_n <= 1'b1;
            end else begin
                input_ready_n <= ir1_r;
            end
        end
    end

    // Words held including the output register; one more in fall-through
    assign tot17 = 17'(cnt_r) + 17'(ov_r);
    assign n17 = 17'(empty_ofs_r);
    assign m17 = 17'(full_ofs_r);
    assign fw17 = 17'(fall_through_mode);

    // Level flags follow the count every cycle
    // They move on clk_sys, not on pin edges, so they may lead the
    // two-stage empty and full flags by up to two pin clock periods
    always_ff @(posedge clk_sys) begin
        if (!rst_n || mrs_act) begin
            almost_empty_flag_n <= 1'b0;
            half_full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end else begin
            almost_empty_flag_n <= (tot17 > n17 + fw17);
            half_full_flag_n <= ~(tot17 > HALF17 + fw17);
            almost_full_flag_n <= ~(tot17 >= D17 - m17 + fw17);
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    // Transfer size is not decoded; every access is taken as a word
    assign addr_ph = hsel & htrans[1] & hready;
    assign status_w = {16'(tot17), 8'h00, fall_through_mode, almost_full_flag_n,
                       half_full_flag_n, almost_empty_flag_n,
                       input_ready_n, output_valid_n, full_flag_n,
                       empty_flag_n};

    // Address phase latched for the write data that follows
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dph_wr_r <= 1'b0;
            dph_addr_r <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dph_wr_r <= addr_ph & hwrite;
            dph_addr_r <= haddr[`DCFF_ADDR_W-1:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data fetched in the address phase so it stands from a flop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (addr_ph && !hwrite) begin
            case (haddr[`DCFF_ADDR_W-1:0])
                `DCFF_ADDR_EMPTY_OFS: hrdata <= 32'(empty_ofs_r);
                `DCFF_ADDR_FULL_OFS: hrdata <= 32'(full_ofs_r);
                `DCFF_ADDR_STATUS: hrdata <= status_w;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Offsets survive master reset; software may change them any time
    // A change takes effect on the next cycle of the level flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            empty_ofs_r <= `DCFF_OFS_RST;
            full_ofs_r <= `DCFF_OFS_RST;
        end else if (dph_wr_r) begin
            case (dph_addr_r)
                `DCFF_ADDR_EMPTY_OFS: empty_ofs_r <= hwdata[`DCFF_OFS_W-1:0];
                `DCFF_ADDR_FULL_OFS: full_ofs_r <= hwdata[`DCFF_OFS_W-1:0];
                default: empty_ofs_r <= empty_ofs_r;
            endcase
        end
    end
endmodule : dcff_core

/* File: testbench/dcff_core_properties.sv */
// Checker of the FIFO core flags and read data, on the core's ports only.
// Assumes a bind from the bench top; clk_sys is the only clock.
module dcff_core_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic mode_select_serial_in,
    input wire logic rd_en_n,
    input wire logic [35:0] read_data_out,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic output_valid_n,
    input wire logic input_ready_n,
    input wire logic half_full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n
);
    logic mode_r;
    logic [2:0] calm_r;
    logic [3:0] age_r;
    wire logic calm = calm_r == 3'h7;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Mode follows the pin while master reset is low; checks wait out the reset synchroniser
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !master_reset_n) calm_r <= 3'h0;
        else if (!calm) calm_r <= calm_r + 3'h1;
        if (!master_reset_n) mode_r <= mode_select_serial_in;
    end
    // Cycles since the reader last asked, saturating
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !rd_en_n) age_r <= 4'h0;
        else if (age_r != 4'hf) age_r <= age_r + 4'h1;
    end
    reset_flags_a: assert property (disable iff (1'b0)
        !rst_n |=> !empty_flag_n && full_flag_n && output_valid_n
        && input_ready_n && !almost_empty_flag_n && half_full_flag_n
        && almost_full_flag_n) else $error("flags wrong after reset");
    plain_ready_a: assert property (calm && !mode_r |->
        input_ready_n && output_valid_n) else $error("fall_through_mode flag in plain");
    fall_through_mode_full_a: assert property (calm && mode_r |->
        full_flag_n) else $error("full flag moved in fall_through_mode");
    full_order_a: assert property (calm && !mode_r && !full_flag_n |->
        empty_flag_n && almost_empty_flag_n && !half_full_flag_n
        && !almost_full_flag_n) else $error("flags disagree at full");
    empty_order_a: assert property (calm && !mode_r && !empty_flag_n |->
        full_flag_n && !almost_empty_flag_n && half_full_flag_n
        && almost_full_flag_n) else $error("flags disagree at empty");
    ready_full_a: assert property (calm && mode_r && input_ready_n |->
        !output_valid_n && !half_full_flag_n && !almost_full_flag_n
        && almost_empty_flag_n) else $error("flags disagree at fall_through_mode full");
    plain_data_a: assert property (calm && !mode_r
        && $changed(read_data_out) |-> age_r < 4'hc)
        else $error("data moved without a read");
    near_full_a: assert property (calm && !almost_full_flag_n |->
        !half_full_flag_n) else $error("almost full but not half full");
endmodule : dcff_core_properties

/* File: testbench/dcff_far_side.sv */
// Writer and reader beside the FIFO core, on free-running pin clocks.
// Assumes the bench calls put and take; strobes move on falling edges.
module dcff_far_side (
    output logic wr_clk,
    output logic wr_en_n,
    output logic [35:0] wr_data,
    output logic rd_clk,
    output logic rd_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin clocks offset from clk_sys and from each other
    initial begin
        {wr_clk, rd_clk, wr_en_n, rd_en_n} = 4'h3;
        wr_data = 36'h0;
        #13;
        fork
            forever #160 wr_clk = ~wr_clk;
            #58 forever #160 rd_clk = ~rd_clk;
        join
    end
    function automatic logic [35:0] word(input int i);
        return {4'h9, 32'(i * 7 + 3)};
    endfunction : word
    // Word held across the rising edge; released lines show no stale word
    task automatic put(input int first, input int count);
        for (int i = 0; i < count; i++) begin
            @(negedge wr_clk);
            wr_en_n = 1'b0;
            wr_data = word(first + i);
        end
        @(negedge wr_clk);
        wr_en_n = 1'b1;
        wr_data = ~wr_data;
    endtask : put
    // Every word is asked for, one read edge each
    task automatic take(input int count);
        for (int i = 0; i < count; i++) begin
            @(negedge rd_clk);
            rd_en_n = 1'b0;
        end
        @(negedge rd_clk);
        rd_en_n = 1'b1;
    endtask : take
endmodule : dcff_far_side

/* File: testbench/dcff_core_bench.sv */
// Bench of the FIFO core: both read modes, all flags, offset registers.
// Assumes the far-side model drives the pin clocks and strobes.
`include "dcff_cfg.svh"
module dcff_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 1024;
    localparam int N = 4;
    localparam int M = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic master_reset_n = 1'b0;
    logic mode_pin = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wr_clk, wr_en_n, rd_clk, rd_en_n;
    logic [35:0] wr_data, read_data_out;
    logic [31:0] hrdata, st;
    logic empty_flag_n, full_flag_n, output_valid_n, input_ready_n;
    logic half_full_flag_n, almost_empty_flag_n, almost_full_flag_n;
    int miscompares = 0;
    int samples_checked = 0;
    int cnt, rdn;
    dcff_core #(.DEPTH(D)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .master_reset_n(master_reset_n), .mode_select_serial_in(mode_pin),
        .wr_clk(wr_clk), .wr_en_n(wr_en_n), .wr_data(wr_data),
        .rd_clk(rd_clk), .rd_en_n(rd_en_n), .read_data_out(read_data_out),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .output_valid_n(output_valid_n), .input_ready_n(input_ready_n),
        .half_full_flag_n(half_full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp));
    dcff_far_side far (.wr_clk(wr_clk), .wr_en_n(wr_en_n),
        .wr_data(wr_data), .rd_clk(rd_clk), .rd_en_n(rd_en_n));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    // Bounded wait for hready; a stuck bus ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 32);
        if (hreadyout !== 1'b1) begin
            check(36'h0, 36'h1);
            complete_run();
        end
    endtask : wait_ready
    // One single AHB-Lite word, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input int wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(wd);
        wait_ready();
        st = hrdata;
        check(36'(hresp), 36'h0);
    endtask : bus
    function automatic logic [4:0] want(input logic fw, input int k);
        if (fw) return {k == 0, k > D, k > N + 1, k <= D / 2 + 1, k < D + 1 - M};
        return {k > 0, k < D, k > N, k <= D / 2, k < D - M};
    endfunction : want
    function automatic logic [4:0] seen(input logic fw);
        return {fw ? output_valid_n : empty_flag_n,
            fw ? input_ready_n : full_flag_n, almost_empty_flag_n,
            half_full_flag_n, almost_full_flag_n};
    endfunction : seen
    // Flags and word once the pin clocks have carried the change across
    task automatic verify(input logic fw);
        repeat (4) @(posedge rd_clk);
        repeat (6) @(posedge clk_sys);
        check(36'(seen(fw)), 36'(want(fw, cnt)));
        if (fw && cnt > 0) check(read_data_out, far.word(rdn));
        if (!fw) check(read_data_out, rdn > 0 ? far.word(rdn - 1) : 36'h0);
    endtask : verify
    // Writes past the capacity are dropped, so the count saturates
    task automatic fill(input logic fw, input int to);
        far.put(cnt, to - cnt);
        cnt = to > D + int'(fw) ? D + int'(fw) : to;
        verify(fw);
    endtask : fill
    task automatic drain(input logic fw, input int to);
        far.take(cnt - to);
        rdn += cnt - to;
        cnt = to;
        verify(fw);
    endtask : drain
    // Mode pin stays put through master reset and after it
    task automatic run_mode(input logic fw);
        int f;
        f = int'(fw);
        mode_pin <= fw;
        master_reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        master_reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        cnt = 0;
        rdn = 0;
        bus(1'b0, `DCFF_ADDR_STATUS, 0);
        check(36'(st[7]), 36'(fw));
        fill(fw, 1);
        fill(fw, N + f);
        fill(fw, N + 1 + f);
        fill(fw, D / 2 + f);
        fill(fw, D / 2 + 1 + f);
        fill(fw, D - M - 1 + f);
        fill(fw, D - M + f);
        fill(fw, D + 2 + f);
        bus(1'b0, `DCFF_ADDR_STATUS, 0);
        check(36'(st[31:16]), 36'(D + f));
        drain(fw, D - 1 + f);
        drain(fw, N + 1 + f);
        drain(fw, N + f);
        drain(fw, 1);
        drain(fw, 0);
        drain(fw, 0);
    endtask : run_mode
    // Reset, offset registers, then each read mode in turn
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check(36'({empty_flag_n, full_flag_n, output_valid_n, input_ready_n,
            almost_empty_flag_n, half_full_flag_n, almost_full_flag_n}),
            36'h3b);
        bus(1'b0, `DCFF_ADDR_EMPTY_OFS, 0);
        check(36'(st), 36'(`DCFF_OFS_RST));
        bus(1'b1, `DCFF_ADDR_EMPTY_OFS, N);
        bus(1'b1, `DCFF_ADDR_FULL_OFS, M);
        bus(1'b0, `DCFF_ADDR_FULL_OFS, 0);
        check(36'(st), 36'(M));
        bus(1'b0, 8'h0c, 0);
        check(36'(st), 36'h0);
        run_mode(1'b0);
        run_mode(1'b1);
        complete_run();
    end
endmodule : dcff_core_bench
bind dcff_core dcff_core_properties u_props (.*);
